// ---- hdl/ssmspi_core.v ----
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssmspi_consts.vh"

module ssmspi_core
(
    input  wire       clock,
    input  wire       rst_n,
    input  wire [1:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrStb,
    input  wire       regRdStb,
    output reg  [7:0] regRdData_r,
    input  wire       sckIn,
    output reg        sckOut_r,
    output reg        sckOe_r,
    input  wire       sdioIn,
    output reg        sdioOut_r,
    output reg        sdioOe_r,
    output reg        sdoOut_r,
    output reg        sdoOe_r,
    input  wire       slaveSelectInN,
    output reg        slaveSelectOutN_r,
    output reg        slaveSelectOe_r,
    input  wire       subClkIn,
    input  wire       tmrOvfIn,
    output reg        irqPulse_r
);

    // Control and status fields of serial_mode_control.
    reg  [2:0] opMode_r;
    reg        pinFlt_r;
    reg        dirTx_r;
    reg        wire3_r;
    reg        enable_r;
    reg        icf_r;
    // Control and status fields of serial_format_control.
    reg        spare7_r;
    reg        polLow_r;
    reg        edgeSel_r;
    reg        msbFirst_r;
    reg        select_pin_control_r;
    reg        write_collision_flag_r;
    reg        trf_r;
    // Data path and sequencing state.
    reg  [7:0] dataReg_r;
    reg  [7:0] txReg_r;
    reg  [7:0] rxReg_r;
    reg  [3:0] capCnt_r;
    reg  [4:0] edgeCnt_r;
    reg  [2:0] outIdx_r;
    reg        busy_r;
    reg        sdioDrive_r;

    wire       spiOn;
    wire       isMaster;
    wire       isSlave;
    wire       receiving;
    wire       idleLvl;
    wire       slvSelected;
    wire       halfTick;
    wire       sckRise;
    wire       sckFall;
    wire       ssRise;
    wire       ssFall;
    wire       mEdge;
    wire       sEdge;
    wire       edgeEv;
    wire       leadEv;
    wire       capEv;
    wire       shiftEv;
    wire       inBusy;
    wire       wrMode;
    wire       wrFmt;
    wire       wrData;
    wire       collide;
    wire       startXfer;
    wire       mDone;
    wire       sDone;
    wire       abortEv;
    wire       doneEv;
    wire       txBit;
    reg  [7:0] rxNext;

    assign spiOn     = enable_r && (opMode_r != `SSMSPI_OM_TWOWIRE) && (opMode_r != `SSMSPI_OM_UNUSED);
    assign isMaster  = (opMode_r <= `SSMSPI_OM_TIMER);
    assign isSlave   = (opMode_r == `SSMSPI_OM_SLAVE);
    assign receiving = !wire3_r || !dirTx_r;
    assign idleLvl   = ~polLow_r;
    assign slvSelected = !select_pin_control_r || !slaveSelectInN;

    // Master shift clock source: divided system clock, sub clock or timer overflow.
    // clock source select
    ssmspi_tick_gen
    #(
        .CNT_W    (6)
    )
    u_tick
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .run      (busy_r),
        .srcSel   (opMode_r),
        .subClkIn (subClkIn),
        .tmrOvfIn (tmrOvfIn),
        .halfTick (halfTick)
    );

    // Edges of the external clock, used only in slave operation.
    ssmspi_edge_det u_sck
    (
        .clock (clock),
        .rst_n (rst_n),
        .level (sckIn),
        .rise  (sckRise),
        .fall  (sckFall)
    );

    // A rising select line breaks off a slave byte; a whole byte ends on its eighth capture edge.
    ssmspi_edge_det u_ss
    (
        .clock (clock),
        .rst_n (rst_n),
        .level (slaveSelectInN),
        .rise  (ssRise),
        .fall  (ssFall)
    );

    // The master times its own edges; the slave only follows the external clock.
    // slave uses external clock
    assign mEdge  = spiOn && isMaster && busy_r && halfTick;
    assign sEdge  = spiOn && isSlave && slvSelected && (sckRise || sckFall);
    assign edgeEv = mEdge || sEdge;
    assign leadEv = isMaster ? (sckOut_r == idleLvl) : (polLow_r ? sckRise : sckFall);

    // The edge bit set means capture on the leading edge, clear means trailing.
    // capture edge choice
    assign capEv   = edgeEv && (edgeSel_r ? leadEv : !leadEv);
    // The very first leading edge in trailing-capture form presents bit 0, not bit 1.
    assign shiftEv = edgeEv && (edgeSel_r ? !leadEv : leadEv) && (capCnt_r != 4'd0);

    assign txBit = msbFirst_r ? txReg_r[3'd7 - outIdx_r] : txReg_r[outIdx_r];

    // Incoming bit merged into the receive shifter in the chosen order.
    always @*
    begin
        rxNext = rxReg_r;
        if (capEv)
            rxNext = msbFirst_r ? {rxReg_r[6:0], sdioIn} : {sdioIn, rxReg_r[7:1]};
    end

    // Register port decode.
    assign wrMode = regWrStb && (regAddr == `SSMSPI_ADDR_MODE);
    assign wrFmt  = regWrStb && (regAddr == `SSMSPI_ADDR_FORMAT);
    assign wrData = regWrStb && (regAddr == `SSMSPI_ADDR_DATA);

    // A byte is in flight while the master runs or the slave has counted clocks.
    assign inBusy    = busy_r || (capCnt_r != 4'd0);
    assign collide   = wrData && inBusy;
    assign startXfer = wrData && !inBusy && spiOn && isMaster;

    // Master ends on the sixteenth edge so the clock is back at idle level.
    assign mDone   = mEdge && (edgeCnt_r == `SSMSPI_LAST_EDGE);
    assign sDone   = sEdge && capEv && (capCnt_r == `SSMSPI_LAST_BIT);
    assign abortEv = spiOn && isSlave && select_pin_control_r && ssRise && (capCnt_r != 4'd0);
    assign doneEv  = mDone || sDone;

    // Control registers: only software writes them, so enabling the module keeps them.
    // contents kept on enable
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            opMode_r   <= `SSMSPI_OM_UNUSED;
            pinFlt_r   <= 1'b0;
            dirTx_r    <= 1'b0;
            wire3_r    <= 1'b0;
            enable_r   <= 1'b0;
            spare7_r   <= 1'b0;
            polLow_r   <= 1'b0;
            edgeSel_r  <= 1'b0;
            msbFirst_r <= 1'b0;
            select_pin_control_r     <= 1'b0;
        end
        else
        begin
            if (wrMode)
            begin
                opMode_r <= regWrData[`SSMSPI_OM_HI:`SSMSPI_OM_LO];
                pinFlt_r <= regWrData[`SSMSPI_FLT_BIT];
                dirTx_r  <= regWrData[`SSMSPI_DIR_BIT];
                wire3_r  <= regWrData[`SSMSPI_WIRE_BIT];
                enable_r <= regWrData[`SSMSPI_EN_BIT];
            end
            if (wrFmt)
            begin
                spare7_r   <= regWrData[`SSMSPI_SPARE_BIT];
                polLow_r   <= regWrData[`SSMSPI_POL_BIT];
                edgeSel_r  <= regWrData[`SSMSPI_EDGE_BIT];
                msbFirst_r <= regWrData[`SSMSPI_ORDER_BIT];
                select_pin_control_r     <= regWrData[`SSMSPI_SELECT_PIN_CONTROL_BIT];
            end
        end
    end

    // Status flags: a hardware set in the same cycle as a software clear wins.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            icf_r      <= 1'b0;
            write_collision_flag_r     <= 1'b0;
            trf_r      <= 1'b0;
            irqPulse_r <= 1'b0;
        end
        else
        begin
            if (abortEv)
                icf_r <= 1'b1;
            else if (wrMode)
                icf_r <= regWrData[`SSMSPI_ICF_BIT];
            if (collide)
                write_collision_flag_r <= 1'b1;
            else if (wrFmt)
                write_collision_flag_r <= regWrData[`SSMSPI_WRITE_COLLISION_FLAG_BIT];
            if (doneEv || abortEv)
                trf_r <= 1'b1;
            else if (wrFmt)
                trf_r <= regWrData[`SSMSPI_TRF_BIT];
            irqPulse_r <= doneEv || abortEv;
        end
    end

    // Transfer sequencer and shared data register.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            dataReg_r   <= `SSMSPI_DATA_RST;
            txReg_r     <= `SSMSPI_DATA_RST;
            rxReg_r     <= `SSMSPI_DATA_RST;
            capCnt_r    <= 4'd0;
            edgeCnt_r   <= 5'd0;
            outIdx_r    <= 3'd0;
            busy_r      <= 1'b0;
            sdioDrive_r <= 1'b0;
            sckOut_r    <= 1'b1;
        end
        else if (!spiOn)
        begin
            // Disabled: everything in flight is dropped, data stays readable.
            if (wrData)
            begin
                dataReg_r <= regWrData;
                txReg_r   <= regWrData;
            end
            capCnt_r    <= 4'd0;
            edgeCnt_r   <= 5'd0;
            outIdx_r    <= 3'd0;
            busy_r      <= 1'b0;
            sdioDrive_r <= 1'b0;
            sckOut_r    <= idleLvl;
        end
        else
        begin
            if (wrData && !inBusy)
            begin
                dataReg_r <= regWrData;
                txReg_r   <= regWrData;
                outIdx_r  <= 3'd0;
                rxReg_r   <= `SSMSPI_DATA_RST;
                if (wire3_r && dirTx_r)
                    sdioDrive_r <= 1'b1;
            end
            else if (wrMode && !regWrData[`SSMSPI_DIR_BIT] && !inBusy)
                sdioDrive_r <= 1'b0; // direction clear releases
            if (startXfer)
            begin
                busy_r    <= 1'b1;
                edgeCnt_r <= 5'd0;
                capCnt_r  <= 4'd0;
            end
            if (!busy_r && !startXfer)
                sckOut_r <= idleLvl;
            if (mEdge)
            begin
                sckOut_r  <= ~sckOut_r;
                edgeCnt_r <= edgeCnt_r + 5'd1;
            end
            if (capEv)
            begin
                rxReg_r  <= rxNext;
                capCnt_r <= capCnt_r + 4'd1;
            end
            if (shiftEv)
                outIdx_r <= outIdx_r + 3'd1;
            if (doneEv)
            begin
                busy_r    <= 1'b0;
                capCnt_r  <= 4'd0;
                outIdx_r  <= 3'd0;
                edgeCnt_r <= 5'd0;
                if (receiving)
                    dataReg_r <= rxNext;
                if (wire3_r && dirTx_r && pinFlt_r)
                    sdioDrive_r <= 1'b0;
            end
            if (abortEv)
            begin
                capCnt_r <= 4'd0;
                outIdx_r <= 3'd0;
            end
            else if (isSlave && ssFall)
                outIdx_r <= 3'd0;
        end
    end

    // Pin drivers are registered; they follow the sequencer by one cycle.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            sckOe_r           <= 1'b0;
            sdioOut_r         <= 1'b1;
            sdioOe_r          <= 1'b0;
            sdoOut_r          <= 1'b1;
            sdoOe_r           <= 1'b0;
            slaveSelectOutN_r <= 1'b1;
            slaveSelectOe_r   <= 1'b0;
        end
        else
        begin
            sckOe_r           <= spiOn && isMaster;
            sdoOe_r           <= spiOn && !wire3_r;
            sdoOut_r          <= spiOn ? txBit : 1'b1;
            sdioOe_r          <= spiOn && wire3_r && dirTx_r && sdioDrive_r;
            sdioOut_r         <= txBit;
            slaveSelectOe_r   <= spiOn && isMaster && select_pin_control_r;
            slaveSelectOutN_r <= !busy_r;
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always @(posedge clock)
    begin
        if (!rst_n)
            regRdData_r <= 8'h00;
        else if (regRdStb)
        begin
            case (regAddr)
                `SSMSPI_ADDR_MODE:
                    regRdData_r <= {opMode_r, pinFlt_r, dirTx_r, wire3_r, enable_r, icf_r};
                `SSMSPI_ADDR_FORMAT:
                    regRdData_r <= {spare7_r, (capCnt_r != 4'd0), polLow_r, edgeSel_r,
                                    msbFirst_r, select_pin_control_r, write_collision_flag_r, trf_r};
                `SSMSPI_ADDR_DATA:
                    regRdData_r <= dataReg_r;
                default:
                    regRdData_r <= 8'h00;
            endcase
        end
        else
            regRdData_r <= 8'h00;
    end

endmodule
`default_nettype wire

// ---- pkg/ssmspi_consts.vh ----
`ifndef SSMSPI_CONSTS_VH
`define SSMSPI_CONSTS_VH

// Register word addresses on the plain register port.
`define SSMSPI_ADDR_MODE    2'h0
`define SSMSPI_ADDR_FORMAT  2'h1
`define SSMSPI_ADDR_DATA    2'h2

// Reset values.
`define SSMSPI_MODE_RST     8'hE0
`define SSMSPI_FORMAT_RST   8'h00
`define SSMSPI_DATA_RST     8'h00

// Operating mode field codes.
`define SSMSPI_OM_DIV4      3'h0
`define SSMSPI_OM_DIV16     3'h1
`define SSMSPI_OM_DIV64     3'h2
`define SSMSPI_OM_SUBCLK    3'h3
`define SSMSPI_OM_TIMER     3'h4
`define SSMSPI_OM_SLAVE     3'h5
`define SSMSPI_OM_TWOWIRE   3'h6
`define SSMSPI_OM_UNUSED    3'h7

// Field positions in serial_mode_control.
`define SSMSPI_OM_HI        7
`define SSMSPI_OM_LO        5
`define SSMSPI_FLT_BIT      4
`define SSMSPI_DIR_BIT      3
`define SSMSPI_WIRE_BIT     2
`define SSMSPI_EN_BIT       1
`define SSMSPI_ICF_BIT      0

// Field positions in serial_format_control.
`define SSMSPI_SPARE_BIT    7
`define SSMSPI_ACT_BIT      6
`define SSMSPI_POL_BIT      5
`define SSMSPI_EDGE_BIT     4
`define SSMSPI_ORDER_BIT    3
`define SSMSPI_SELECT_PIN_CONTROL_BIT     2
`define SSMSPI_WRITE_COLLISION_FLAG_BIT     1
`define SSMSPI_TRF_BIT      0

// System clock cycles per half shift-clock period in divided master modes.
`define SSMSPI_HALF_DIV4    6'd2
`define SSMSPI_HALF_DIV16   6'd8
`define SSMSPI_HALF_DIV64   6'd32

// Index of the last shift clock edge in one byte, and of the last captured bit in one byte.
`define SSMSPI_LAST_EDGE    5'd15
`define SSMSPI_LAST_BIT     4'd7

`endif

// ---- hdl/ssmspi_edge_det.v ----
`timescale 1ns/1ps
`default_nettype none

module ssmspi_edge_det
(
    input  wire clock,
    input  wire rst_n,
    input  wire level,
    output wire rise,
    output wire fall
);

    reg prev_r;

    // The previous sample starts high so an idle-high line shows no edge at reset.
    always @(posedge clock)
    begin
        if (!rst_n)
            prev_r <= 1'b1;
        else
            prev_r <= level;
    end

    // Edges are one-cycle pulses seen in the cycle the new level arrives.
    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;

endmodule
`default_nettype wire

// ---- hdl/ssmspi_tick_gen.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ssmspi_consts.vh"

module ssmspi_tick_gen
#(
    parameter CNT_W = 6
)
(
    input  wire       clock,
    input  wire       rst_n,
    input  wire       run,
    input  wire [2:0] srcSel,
    input  wire       subClkIn,
    input  wire       tmrOvfIn,
    output reg        halfTick
);

    reg  [CNT_W-1:0] cnt_r;
    reg              subPrev_r;
    reg  [CNT_W-1:0] halfLen;
    wire             subEdge;

    // Both sub clock edges count, so the shift clock runs at the sub clock rate.
    assign subEdge = subClkIn ^ subPrev_r;

    // Half period length for the divided system clock sources.
    always @*
    begin
        case (srcSel)
            `SSMSPI_OM_DIV4:  halfLen = `SSMSPI_HALF_DIV4;
            `SSMSPI_OM_DIV16: halfLen = `SSMSPI_HALF_DIV16;
            default:          halfLen = `SSMSPI_HALF_DIV64;
        endcase
    end

    // The counter restarts with each transfer so the first half period is full length.
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnt_r     <= {CNT_W{1'b0}};
            subPrev_r <= 1'b0;
            halfTick  <= 1'b0;
        end
        else
        begin
            subPrev_r <= subClkIn;
            halfTick  <= 1'b0;
            if (!run)
                cnt_r <= {CNT_W{1'b0}};
            else if (srcSel == `SSMSPI_OM_SUBCLK)
                halfTick <= subEdge;
            else if (srcSel == `SSMSPI_OM_TIMER)
                halfTick <= tmrOvfIn; // Two overflows make one shift clock period.
            else if (cnt_r == halfLen - {{(CNT_W-1){1'b0}}, 1'b1})
            begin
                cnt_r    <= {CNT_W{1'b0}};
                halfTick <= 1'b1;
            end
            else
                cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule
`default_nettype wire

// ---- verif/ssmspi_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssmspi_consts.vh"

module ssmspi_core_props
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regRdData_r,
    input wire logic       sckOut_r,
    input wire logic       sckOe_r,
    input wire logic       sdioOe_r,
    input wire logic       sdoOe_r,
    input wire logic       slaveSelectOutN_r,
    input wire logic       slaveSelectOe_r,
    input wire logic       irqPulse_r
);
    logic [7:0] modeSh_r;
    logic [7:0] fmtSh_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Shadows of software writes; outputs lag the registers, so checks wait a few cycles.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            modeSh_r <= `SSMSPI_MODE_RST;
            fmtSh_r  <= `SSMSPI_FORMAT_RST;
        end
        else if (regWrStb && regAddr == `SSMSPI_ADDR_MODE)
            modeSh_r <= regWrData;
        else if (regWrStb && regAddr == `SSMSPI_ADDR_FORMAT)
            fmtSh_r <= regWrData;
    end

    a_mode_readback: assert property (regRdStb && regAddr == `SSMSPI_ADDR_MODE |=>
        regRdData_r[7:1] == modeSh_r[7:1]) else $error("mode register read back wrong");
    a_unmapped_zero: assert property (regRdStb && regAddr == 2'h3 |=> regRdData_r == 8'h00)
        else $error("unmapped address read not zero");
    a_disabled_quiet: assert property ((modeSh_r[1] == 1'b0)[*3] |->
        !sckOe_r && !sdoOe_r && !sdioOe_r && !slaveSelectOe_r) else $error("pin driven while disabled");
    a_slave_no_clock: assert property ((modeSh_r[7:5] == 3'h5)[*3] |-> !sckOe_r)
        else $error("slave drives the shift clock");
    a_master_drives_clock: assert property ((modeSh_r[7:5] < 3'h5 && modeSh_r[1])[*3] |-> sckOe_r)
        else $error("enabled master not driving clock");
    a_select_float: assert property ((fmtSh_r[2] == 1'b0)[*3] |-> !slaveSelectOe_r)
        else $error("select pin driven while disabled");
    a_irq_single: assert property (irqPulse_r |=> !irqPulse_r)
        else $error("interrupt pulse longer than one cycle");
    a_idle_level: assert property (irqPulse_r && sckOe_r |=> sckOut_r == ~fmtSh_r[5])
        else $error("clock not idle after byte");
    a_byte_bounded: assert property ($fell(slaveSelectOutN_r) |-> ##[16:600] irqPulse_r)
        else $error("master byte did not complete");
endmodule

bind ssmspi_core ssmspi_core_props i_props
(
    .clock(clock),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .regRdStb(regRdStb),
    .regRdData_r(regRdData_r),
    .sckOut_r(sckOut_r),
    .sckOe_r(sckOe_r),
    .sdioOe_r(sdioOe_r),
    .sdoOe_r(sdoOe_r),
    .slaveSelectOutN_r(slaveSelectOutN_r),
    .slaveSelectOe_r(slaveSelectOe_r),
    .irqPulse_r(irqPulse_r)
);

`default_nettype wire

// ---- verif/ssmspi_far_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssmspi_far_peer
(
    input  wire logic       sck,
    input  wire logic       serial_out_pin,
    input  wire logic       pol,
    input  wire logic       edgeSel,
    input  wire logic       msb,
    input  wire logic       arm,
    input  wire logic [7:0] txByte,
    output var  logic [7:0] rxByte,
    output wire logic       sdi
);
    int cnt;
    int idx;

    // Counters restart whenever the testbench arms the peer for a new byte.
    always @(posedge arm)
    begin
        cnt = 0;
        idx = 0;
    end

    // shift on clock
    // Data moves on the launch edge only, half a period away from capture, so no hold race.
    always @(sck)
    begin
        if (arm && sck == (pol ~^ edgeSel))
        begin
            rxByte = msb ? {rxByte[6:0], serial_out_pin} : {serial_out_pin, rxByte[7:1]};
            cnt = cnt + 1;
        end
        else if (arm)
            idx = (cnt > 7) ? 7 : cnt;
    end

    // Released line shows the inverse of the last bit rather than a stale copy.
    assign sdi = arm ? txByte[msb ? 7 - idx : idx] : ~txByte[msb ? 0 : 7];
endmodule

`default_nettype wire

// ---- verif/ssmspi_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssmspi_core_tb;
    logic       clock, rst_n, regWrStb, regRdStb, tbSck, tbSsN, arm;
    logic       subClk = 1'b0, tmrOvf = 1'b0;
    logic [1:0] regAddr;
    logic [7:0] regWrData, ptx, fmtCfg;
    logic [2:0] div = 3'h0;
    wire  logic [7:0] rdData, prx;
    wire  logic sckOut, sckOe, sdioOut, sdioOe, sdoOut, sdoOe, ssOut, ssOe, irq, sdi;
    int         bad_count, compares, n, i;
    int         irqCnt = 0;
    int         hv[5] = '{2, 8, 32, 5, 5};
    logic [7:0] fv[5] = '{8'h08, 8'h30, 8'h18, 8'h24, 8'h38};
    // Wire levels resolved from whoever drives each pin.
    wire  logic sckW = sckOe ? sckOut : tbSck;
    wire  logic sdioW = sdioOe ? sdioOut : sdi;
    wire  logic ssW = ssOe ? ssOut : tbSsN;
    wire  logic txW = sdoOe ? sdoOut : sdioOut;

    ssmspi_core i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_r(rdData), .sckIn(sckW), .sckOut_r(sckOut),
        .sckOe_r(sckOe), .sdioIn(sdioW), .sdioOut_r(sdioOut), .sdioOe_r(sdioOe), .sdoOut_r(sdoOut),
        .sdoOe_r(sdoOe), .slaveSelectInN(ssW), .slaveSelectOutN_r(ssOut), .slaveSelectOe_r(ssOe),
        .subClkIn(subClk), .tmrOvfIn(tmrOvf), .irqPulse_r(irq));
    ssmspi_far_peer i_peer (.sck(sckW), .serial_out_pin(txW), .pol(fmtCfg[5]), .edgeSel(fmtCfg[4]), .msb(fmtCfg[3]),
        .arm(arm), .txByte(ptx), .rxByte(prx), .sdi(sdi));

    task print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask

    // An idle edge follows each strobe, so back-to-back calls never assign a strobe twice in one step.
    task wr(input logic [1:0] a, input logic [7:0] d);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrStb <= 1'b0;
        @(posedge clock);
    endtask

    // Read data stands only in the cycle after the strobe; it is taken at the edge closing that cycle.
    task rd(input logic [1:0] a, output logic [7:0] v);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRdStb <= 1'b0;
        @(posedge clock);
        v = rdData;
    endtask

    task rdc(input logic [1:0] a, input logic [7:0] exp, input string name);
        logic [7:0] v;
        rd(a, v);
        chk(name, v, exp);
    endtask

    task waitTrf(output int cnt);
        logic [7:0] v;
        v = 8'h00;
        cnt = 0;
        while (v[0] !== 1'b1 && cnt < 2000)
        begin
            rd(2'h1, v);
            cnt += 2;
        end
        chk("trf", {7'h0, v[0]}, 8'h01);
    endtask

    task rearm;
        arm <= 1'b0;
        @(posedge clock);
        arm <= 1'b1;
    endtask

    // Slave-mode clock from the testbench, idle high, eight system clocks per half period.
    task sclk(input int k);
        repeat (k)
        begin
            tbSck <= 1'b0;
            repeat (8) @(posedge clock);
            tbSck <= 1'b1;
            repeat (8) @(posedge clock);
        end
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Sub clock toggles every five cycles and the timer overflows once per five cycles.
    always @(posedge clock)
    begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        subClk <= (div == 3'h4) ? ~subClk : subClk;
        tmrOvf <= (div == 3'h2);
        irqCnt <= irqCnt + int'(irq);
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict;
    end

    initial
    begin
        {rst_n, regWrStb, regRdStb, arm} = 4'h0;
        {tbSck, tbSsN, regAddr, regWrData, ptx, fmtCfg} = 0;
        {tbSck, tbSsN} = 2'h3;
        {bad_count, compares} = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(2'h0, 8'hE0, "mode");
        rdc(2'h1, 8'h00, "format");
        rdc(2'h2, 8'h00, "data");
        wr(2'h3, 8'hFF);
        rdc(2'h3, 8'h00, "unmapped");
        wr(2'h1, 8'hC0);
        rdc(2'h1, 8'h80, "format");
        // Master bytes over every master mode, with a collision write right behind each start.
        for (i = 0; i < 5; i++)
        begin
            fmtCfg = fv[i];
            ptx <= 8'h3C - 8'(i);
            wr(2'h1, fv[i]);
            wr(2'h0, {i[2:0], 5'h02});
            rearm;
            wr(2'h2, 8'hA1 + 8'(i));
            wr(2'h2, 8'hFF);
            waitTrf(n);
            chk("span", 8'(n >= 15 * hv[i] && n <= 16 * hv[i] + 8), 8'h01);
            rdc(2'h1, fv[i] | 8'h03, "format");
            rdc(2'h2, 8'h3C - 8'(i), "data");
            chk("peer", prx, 8'hA1 + 8'(i));
        end
        // Three-wire transmit, first returning the pin to input, then keeping it driven.
        fmtCfg = 8'h08;
        wr(2'h1, 8'h08);
        wr(2'h0, 8'h1E);
        rearm;
        wr(2'h2, 8'hC3);
        repeat (2) @(posedge clock);
        chk("sdioOe", {7'h0, sdioOe}, 8'h01);
        waitTrf(n);
        repeat (2) @(posedge clock);
        chk("sdioOe", {7'h0, sdioOe}, 8'h00);
        chk("peer", prx, 8'hC3);
        wr(2'h1, 8'h08);
        wr(2'h0, 8'h0E);
        rearm;
        wr(2'h2, 8'h3C);
        waitTrf(n);
        repeat (2) @(posedge clock);
        chk("sdioOe", {7'h0, sdioOe}, 8'h01);
        rdc(2'h2, 8'h3C, "data");
        wr(2'h0, 8'h06);
        repeat (2) @(posedge clock);
        chk("sdioOe", {7'h0, sdioOe}, 8'h00);
        wr(2'h0, 8'h04);
        repeat (2) @(posedge clock);
        chk("sckOe", {7'h0, sckOe}, 8'h00);
        wr(2'h0, 8'h06);
        rdc(2'h0, 8'h06, "mode");
        rdc(2'h1, 8'h09, "format");
        // Slave: select released after three bits, then a whole byte, then clocks while deselected.
        fmtCfg = 8'h04;
        ptx <= 8'h5A;
        wr(2'h1, 8'h04);
        wr(2'h0, 8'hA2);
        rearm;
        tbSsN <= 1'b0;
        n = irqCnt;
        sclk(3);
        tbSsN <= 1'b1;
        repeat (6) @(posedge clock);
        rdc(2'h0, 8'hA3, "mode");
        rdc(2'h1, 8'h05, "format");
        chk("irq", 8'(irqCnt - n), 8'h01);
        wr(2'h0, 8'hA2);
        wr(2'h1, 8'h04);
        rearm;
        tbSsN <= 1'b0;
        sclk(8);
        tbSsN <= 1'b1;
        repeat (6) @(posedge clock);
        rdc(2'h2, 8'h5A, "data");
        chk("peer", prx, 8'h3C);
        rdc(2'h0, 8'hA2, "mode");
        rdc(2'h1, 8'h05, "format");
        wr(2'h1, 8'h04);
        wr(2'h0, 8'hA3);
        rdc(2'h1, 8'h04, "format");
        sclk(2);
        rdc(2'h1, 8'h04, "format");
        print_verdict;
    end
endmodule

`default_nettype wire
